// File: bench/can_peer.sv
/*
  Peer nodes on the bus: receive objects and sync as one-cycle pulses.
  Assumes the bench calls its task from the block's clock domain.
*/
`timescale 1ns/1ns

module can_peer
  import node_status_pkg::*;
#(
  parameter int       N    = 10,
  parameter bitrate_t RATE = BR_250K
)(
  output logic [N-1:0] rpdo_rx,
  output logic         sync_rx,
  input  wire logic    clock
);
  initial
  begin
    rpdo_rx = '0;
    sync_rx = 1'b0;
  end

  // Index N sends a sync
  task automatic send(input int idx);
    @(posedge clock);
    if (idx < N) rpdo_rx[idx] <= 1'b1;
    else sync_rx <= 1'b1;
    @(posedge clock);
    rpdo_rx <= '0;
    sync_rx <= 1'b0;
  endtask
endmodule

// File: bench/node_status_tb.sv
/*
  Self-checking bench of the node status block.
  Assumes a 10-cycle millisecond tick and the peer model for receptions.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %0t got %0h want %0h", $time, g, e); end end

module node_status_tb;
  import node_status_pkg::*;
  logic        clock, rst_n, wr_en, rd_en, warning_limit, bus_off, sync_rx, run_led, err_led, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [9:0]  rpdo_rx;
  logic [6:0]  node_id, plc_id;
  logic [3:0]  p;
  node_state_t node_state;
  bitrate_t    bitrate_sel;
  int          fails, num_checks, cycles;

  node_status #(.MS_CYCLES(10)) u_node_status (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .node_state(node_state), .warning_limit(warning_limit), .bus_off(bus_off),
    .sync_rx(sync_rx), .rpdo_rx(rpdo_rx), .plc_node_id(plc_id), .run_led(run_led),
    .err_led(err_led), .irq(irq), .node_id(node_id), .bitrate_sel(bitrate_sel));
  can_peer u_can_peer (.rpdo_rx(rpdo_rx), .sync_rx(sync_rx), .clock(clock));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  // Samples an indicator 10, 250, 450 and 750 ms after a mode change
  task automatic probe(input logic sel);
    int t[4] = '{100, 2500, 4500, 7500};
    int last;
    last = 0;
    for (int k = 0; k < 4; k++)
    begin
      repeat (t[k] - last) @(posedge clock);
      #1 p[3-k] = sel ? err_led : run_led;
      last = t[k];
    end
  endtask

  task automatic set_in(input node_state_t s, input logic w, input logic b);
    @(posedge clock);
    node_state <= s;
    warning_limit <= w;
    bus_off <= b;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h04); `CHK(d, 32'h4)
    `CHK(bitrate_sel, u_can_peer.RATE)
    rd(8'h10); `CHK(d, 32'h5DC)
    rd(8'h3C); `CHK(d, 32'h0)
    `CHK(node_id, 7'h0A)
    rd(8'h40); `CHK(d[26:16], 11'h18A)
    rd(8'h5C); `CHK(d[26:16], 11'h50A)
  endtask

  task automatic t_config();
    wr(8'h04, 32'h7); rd(8'h04); `CHK(bitrate_sel, BR_1M)
    wr(8'h08, 32'h5); rd(8'h08); `CHK(node_id, 7'h05)
    rd(8'h40); `CHK(d[26:16], 11'h180)
    wr(8'h08, 32'h0); wr(8'h04, 32'h4);
    plc_id <= 7'h21;
    rd(8'h40); `CHK(node_id, 7'h21)
    `CHK(d[26:16], 11'h1A1)
  endtask

  task automatic t_cob();
    wr(8'h20, 32'h4);
    wr(8'h44, 32'h180); rd(8'h44); `CHK(d[10:0], 11'h280)
    `CHK(irq, 1'b1)
    rd(8'h1C); `CHK(d[2], 1'b1)
    @(posedge clock);
    #1 `CHK(irq, 1'b0)
    wr(8'h44, 32'h5FF); rd(8'h44); `CHK(d[14:0], 15'h5FF)
    `CHK(d[26:16], 11'h5FF)
  endtask

  task automatic t_leds();
    wr(8'h00, 32'h2);
    set_in(NODE_OPER, 0, 0); probe(0); `CHK(p, 4'hF)
    `CHK(err_led, 1'b0)
    set_in(NODE_PREOP, 0, 0); probe(0); `CHK(p, 4'hA)
    set_in(NODE_STOPPED, 0, 0); probe(0); `CHK(p, 4'h8)
    set_in(NODE_STOPPED, 1, 0); probe(1); `CHK(p, 4'h8)
    set_in(NODE_OPER, 1, 1); probe(1); `CHK(p, 4'hF)
    wr(8'h00, 32'h3);
    set_in(NODE_OPER, 0, 0); probe(0); `CHK(p, 4'hF)
    set_in(NODE_OPER, 1, 0); probe(0); `CHK(p, 4'hE)
    set_in(NODE_OPER, 1, 1); probe(0); `CHK(p, 4'hF)
    `CHK(err_led, 1'b0)
    set_in(NODE_PREOP, 0, 0); repeat (20) @(posedge clock);
    #1 `CHK(run_led, 1'b0)
    wr(8'h00, 32'h0);
  endtask

  task automatic t_sync();
    wr(8'h0C, 32'h3);
    u_can_peer.send(10);
    probe(1); `CHK(p, 4'hA)
    rd(8'h18); `CHK(d[1], 1'b1)
  endtask

  task automatic t_rpdo();
    wr(8'h00, 32'h2); wr(8'h10, 32'h5); wr(8'h24, 32'h201);
    u_can_peer.send(0);
    u_can_peer.send(9);
    rd(8'h14); `CHK(d, 32'h201)
    probe(1); `CHK(p, 4'hA)
    rd(8'h14); `CHK(d, 32'h0)
    rd(8'h1C); `CHK(d[1], 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    {rst_n, wr_en, rd_en, warning_limit, bus_off} = '0;
    addr = '0;
    wdata = '0;
    node_state = NODE_STOPPED;
    plc_id = 7'h0A;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_config();
    t_cob();
    t_leds();
    t_sync();
    t_rpdo();
    report_and_stop();
  end
endmodule

// File: logic/led_pattern.sv
/*
  Indicator pattern generator: steady, blink and counted flashes on a millisecond tick.
  Assumes the mode is stable for whole patterns; a change restarts the pattern.
*/
`timescale 1ns/1ns
`include "node_status_defines.svh"

module led_pattern
  import node_status_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  pattern_if.gen    pif
);

  led_mode_t   mode_q;
  logic [11:0] tm_q;
  logic [2:0]  pulses_q;
  logic        on_q;
  logic        led_q;

  function automatic logic [2:0] flash_count(input led_mode_t m);
    case (m)
      LED_FLASH1: flash_count = 3'd1;
      LED_FLASH3: flash_count = 3'd3;
      LED_FLASH4: flash_count = 3'd4;
      default:    flash_count = 3'd0;
    endcase
  endfunction

  function automatic logic [11:0] half_ms(input led_mode_t m);
    case (m)
      LED_SLOW:   half_ms = `SLOW_PERIOD_MS / 12'd2;
      LED_BUSOFF: half_ms = 12'(`BUSOFF_PERIOD_MS / 13'd2);
      default:    half_ms = `FLASH_HALF_MS;
    endcase
  endfunction

  wire         is_flash  = flash_count(mode_q) != 3'd0;
  wire         in_gap    = is_flash && !on_q && pulses_q == flash_count(mode_q);
  wire [11:0]  phase_len = in_gap ? `FLASH_GAP_MS : half_ms(mode_q);
  wire         phase_end = pif.ms_tick && tm_q >= phase_len - 12'd1;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mode_q   <= LED_OFF;
      tm_q     <= 12'h000;
      pulses_q <= 3'h0;
      on_q     <= 1'b0;
    end
    else if (pif.mode != mode_q)
    begin
      mode_q   <= pif.mode;
      tm_q     <= 12'h000;
      pulses_q <= 3'h0;
      on_q     <= 1'b1;
    end
    else if (phase_end)
    begin
      tm_q     <= 12'h000;
      on_q     <= !on_q;
      pulses_q <= on_q ? pulses_q + 3'd1 : (in_gap ? 3'h0 : pulses_q);
    end
    else if (pif.ms_tick)
      tm_q <= tm_q + 12'd1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      led_q <= 1'b0;
    else
      led_q <= mode_q == LED_ON || (mode_q != LED_OFF && on_q);
  end

  assign pif.led = led_q;

endmodule

// File: logic/node_status.sv
/*
  Node status indication, receive supervision and identifier configuration.
  Assumes status inputs come from logic on the same clock and the register
  port master follows single-cycle strobes with read data one cycle later.
*/
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "node_status_defines.svh"

module node_status
  import node_status_pkg::*;
#(
  parameter int          RPDO_NUM  = 10,
  parameter int unsigned MS_CYCLES = `MS_CYCLES
)(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic [7:0]    addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output logic      [31:0]   rdata,
  input  wire node_state_t   node_state,
  input  wire logic          warning_limit,
  input  wire logic          bus_off,
  input  wire logic          sync_rx,
  input  wire logic [RPDO_NUM-1:0] rpdo_rx,
  input  wire logic [6:0]    plc_node_id,
  output logic               run_led,
  output logic               err_led,
  output logic               irq,
  output logic [6:0]         node_id,
  output bitrate_t           bitrate_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [16:0]          tick_cnt_q;
  logic                 tick_q;
  logic                 single_q;
  logic                 sync_prod_q;
  bitrate_t             bitrate_q;
  logic [6:0]           id_cfg_q;
  logic [6:0]           node_id_q;
  logic [15:0]          sync_tout_q;
  logic [15:0]          rpdo_tout_q;
  logic [RPDO_NUM-1:0]  expect_q;
  logic [3:0]           irq_stat_q;
  logic [3:0]           irq_mask_q;
  logic                 irq_q;
  logic                 bus_off_q;
  logic [31:0]          rdata_q;
  logic                 follow_q [8];
  logic [10:0]          cob_q    [8];
  logic [1:0]           size_q   [8];

  pattern_if run_if ();
  pattern_if err_if ();
  watch_if #(.N(RPDO_NUM)) rpdo_w ();
  watch_if #(.N(1))        sync_w ();

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire        wr_ctrl   = wr_en && addr == `REG_CTRL;
  wire        wr_rate   = wr_en && addr == `REG_BITRATE;
  wire        wr_id     = wr_en && addr == `REG_NODE_ID;
  wire        wr_stout  = wr_en && addr == `REG_SYNC_TOUT;
  wire        wr_rtout  = wr_en && addr == `REG_RPDO_TOUT;
  wire        wr_mask   = wr_en && addr == `REG_IRQ_MASK;
  wire        wr_expect = wr_en && addr == `REG_RPDO_EXPECT;
  wire        rd_irq    = rd_en && addr == `REG_IRQ_STATUS;
  wire        cob_hit   = addr[7:5] == `REG_COB_PAGE && addr[1:0] == 2'b00;
  wire [2:0]  cob_idx   = addr[4:2];
  wire        id_dyn    = id_cfg_q == 7'h00;
  wire        req_follow = wdata[`COB_FOLLOW_BIT];
  wire        cob_ok    = wdata[10:0] >= `COB_MIN && wdata[10:0] <= `COB_MAX;
  wire        wr_cob    = wr_en && cob_hit && (req_follow || cob_ok);
  wire        cob_rej   = wr_en && cob_hit && !req_follow && !cob_ok;

  function automatic logic [10:0] cob_eff(input logic follow, input logic [10:0] val,
                                          input logic dyn, input logic [6:0] id);
    cob_eff = (follow && dyn) ? val + {4'h0, id} : val;
  endfunction

  function automatic logic [10:0] cob_default(input int i);
    cob_default = (i < 4 ? `TX_COB_BASE : `RX_COB_BASE) + 11'(i % 4) * `COB_STEP;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick

  always_ff @(posedge clock)
  begin
    if (!rst_n || tick_cnt_q == 17'(MS_CYCLES - 1))
      tick_cnt_q <= 17'h00000;
    else
      tick_cnt_q <= tick_cnt_q + 17'd1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      tick_q <= 1'b0;
    else
      tick_q <= tick_cnt_q == 17'(MS_CYCLES - 1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      single_q    <= 1'b0;
      sync_prod_q <= 1'b0;
      bitrate_q   <= BR_250K;
      id_cfg_q    <= 7'h00;
      sync_tout_q <= `SYNC_TOUT_DEF_MS;
      rpdo_tout_q <= `RPDO_TOUT_DEF_MS;
      expect_q    <= RPDO_NUM'(`RPDO_EXPECT_DEF);
      irq_mask_q  <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        single_q    <= wdata[`CTRL_SINGLE_BIT];
        sync_prod_q <= wdata[`CTRL_SYNC_PROD_BIT];
      end
      if (wr_rate)
        bitrate_q <= bitrate_t'(wdata[2:0]);
      if (wr_id)
        id_cfg_q <= wdata[6:0];
      if (wr_stout)
        sync_tout_q <= wdata[15:0];
      if (wr_rtout)
        rpdo_tout_q <= wdata[15:0];
      if (wr_expect)
        expect_q <= wdata[RPDO_NUM-1:0];
      if (wr_mask)
        irq_mask_q <= wdata[3:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      node_id_q <= 7'h00;
    else
      node_id_q <= id_dyn ? plc_node_id : id_cfg_q;
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_cob
    always_ff @(posedge clock)
    begin
      if (!rst_n)
      begin
        follow_q[i] <= 1'b1;
        cob_q[i]    <= cob_default(i);
        size_q[i]   <= `COB_SIZE_DEF;
      end
      else if (wr_cob && cob_idx == 3'(i))
      begin
        follow_q[i] <= req_follow;
        cob_q[i]    <= wdata[10:0];
        size_q[i]   <= wdata[`COB_SIZE_LSB+1:`COB_SIZE_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervision

  assign rpdo_w.ms_tick  = tick_q;
  assign rpdo_w.limit_ms = rpdo_tout_q;
  assign rpdo_w.enable   = expect_q;
  assign rpdo_w.seen     = rpdo_rx;
  assign sync_w.ms_tick  = tick_q;
  assign sync_w.limit_ms = sync_tout_q;
  assign sync_w.enable   = !sync_prod_q;
  assign sync_w.seen     = sync_rx;

  timeout_watch #(.N(RPDO_NUM)) u_rpdo_watch (.clock(clock), .rst_n(rst_n), .w(rpdo_w));
  timeout_watch #(.N(1))        u_sync_watch (.clock(clock), .rst_n(rst_n), .w(sync_w));

  wire rpdo_lost = |(rpdo_w.timed_out & expect_q);
  wire sync_lost = sync_w.timed_out[0];

  ////////////////////////////////////////////////////////////////////////////
  // Indicator selection

  wire led_mode_t run_dual   = node_state == NODE_OPER    ? LED_ON :
                               node_state == NODE_STOPPED ? LED_FLASH1 : LED_BLINK;
  wire led_mode_t run_single = bus_off                    ? LED_BUSOFF :
                               warning_limit              ? LED_SLOW :
                               node_state == NODE_OPER    ? LED_ON : LED_OFF;
  wire led_mode_t err_dual   = bus_off       ? LED_ON :
                               rpdo_lost     ? LED_FLASH4 :
                               sync_lost     ? LED_FLASH3 :
                               warning_limit ? LED_FLASH1 : LED_OFF;

  assign run_if.mode    = single_q ? run_single : run_dual;
  assign err_if.mode    = single_q ? LED_OFF : err_dual;
  assign run_if.ms_tick = tick_q;
  assign err_if.ms_tick = tick_q;

  led_pattern u_run_led (.clock(clock), .rst_n(rst_n), .pif(run_if));
  led_pattern u_err_led (.clock(clock), .rst_n(rst_n), .pif(err_if));

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  wire [3:0] events = {bus_off && !bus_off_q, cob_rej, |(rpdo_w.expired & expect_q),
                       sync_w.expired[0]};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bus_off_q  <= 1'b0;
      irq_stat_q <= 4'h0;
      irq_q      <= 1'b0;
    end
    else
    begin
      bus_off_q  <= bus_off;
      irq_stat_q <= (rd_irq ? 4'h0 : irq_stat_q) | events;   // Set wins over read clear
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire [31:0] cob_word = {5'h00, cob_eff(follow_q[cob_idx], cob_q[cob_idx], id_dyn, node_id_q),
                          1'b0, size_q[cob_idx], follow_q[cob_idx], 1'b0, cob_q[cob_idx]};
  wire [31:0] rd_mux =
    addr == `REG_CTRL        ? {30'h0, sync_prod_q, single_q} :
    addr == `REG_BITRATE     ? {29'h0, bitrate_q} :
    addr == `REG_NODE_ID     ? {17'h0, node_id_q, 1'b0, id_cfg_q} :
    addr == `REG_SYNC_TOUT   ? {16'h0, sync_tout_q} :
    addr == `REG_RPDO_TOUT   ? {16'h0, rpdo_tout_q} :
    addr == `REG_RPDO_STATUS ? 32'(rpdo_w.alive) :
    addr == `REG_MOD_STATUS  ? 32'({sync_lost, 1'b0}) :
    addr == `REG_IRQ_STATUS  ? {28'h0, irq_stat_q} :
    addr == `REG_IRQ_MASK    ? {28'h0, irq_mask_q} :
    addr == `REG_RPDO_EXPECT ? 32'(expect_q) :
    cob_hit                  ? cob_word : 32'h0000_0000;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rd_en ? rd_mux : 32'h0000_0000;
  end

  assign rdata       = rdata_q;
  assign run_led     = run_if.led;
  assign err_led     = err_if.led;
  assign irq         = irq_q;
  assign node_id     = node_id_q;
  assign bitrate_sel = bitrate_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_err_mode_settled;
    single_q [*4];
  endsequence

  a_single_err_dark: assert property (s_err_mode_settled |-> !err_led)
    else $error("error indicator lit in single mode");
  a_run_stop_flash: assert property (!single_q && node_state == NODE_STOPPED
                                     |-> run_if.mode == LED_FLASH1)
    else $error("stopped node not single flashing");
  a_run_oper_on: assert property (run_if.mode == LED_ON [*3] |-> run_led)
    else $error("operational run indicator not lit");
  a_err_busoff_on: assert property (!single_q && bus_off |-> err_if.mode == LED_ON)
    else $error("bus off not steady on");
  a_err_quad_flash: assert property (!single_q && !bus_off && rpdo_lost
                                     |-> err_if.mode == LED_FLASH4)
    else $error("receive timeout not quadruple flash");
  a_err_sync_triple: assert property (!single_q && !bus_off && !rpdo_lost && sync_lost
                                      |-> err_if.mode == LED_FLASH3)
    else $error("sync timeout not triple flash");
  a_single_busoff_slow: assert property (single_q && bus_off
                                         |-> run_if.mode == LED_BUSOFF)
    else $error("bus off not five second blink");
  a_single_warn_blink: assert property (single_q && !bus_off && warning_limit
                                        |-> run_if.mode == LED_SLOW)
    else $error("warning not one second blink");
  a_cob_reject_hold: assert property (cob_rej && cob_idx == 3'h1
                                      |=> cob_q[1] == $past(cob_q[1]))
    else $error("out of range identifier stored");
  a_rpdo_alive_set: assert property (rpdo_rx[0] && expect_q[0]
                                     |=> rpdo_w.alive[0] ##1
                                         (rdata[0] || !$past(rd_en && addr == `REG_RPDO_STATUS)))
    else $error("receive status bit not set");
  a_node_id_dyn: assert property (id_dyn && $stable(plc_node_id)
                                  |=> node_id == $past(plc_node_id))
    else $error("dynamic node id not adopted");
  a_sync_status_read: assert property (rd_en && addr == `REG_MOD_STATUS
                                       |=> rdata[`MOD_SYNC_TOUT_BIT] == $past(sync_lost))
    else $error("sync timeout bit wrong");

endmodule

// File: logic/node_status_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the node status block.
  Assumes a 125 MHz clock and a word-wide register port with byte addresses.
*/
`ifndef NODE_STATUS_DEFINES_SVH
`define NODE_STATUS_DEFINES_SVH

`define MS_NS              1000000
`define CLK_PERIOD_NS      8
`define MS_CYCLES          (`MS_NS / `CLK_PERIOD_NS)
`define FLASH_HALF_MS      12'd200
`define FLASH_GAP_MS       12'd1000
`define SLOW_PERIOD_MS     12'd1000
`define BUSOFF_PERIOD_MS   13'd5000
`define RPDO_TOUT_DEF_MS   16'd1500
`define SYNC_TOUT_DEF_MS   16'd100

`define REG_CTRL           8'h00
`define REG_BITRATE        8'h04
`define REG_NODE_ID        8'h08
`define REG_SYNC_TOUT      8'h0C
`define REG_RPDO_TOUT      8'h10
`define REG_RPDO_STATUS    8'h14
`define REG_MOD_STATUS     8'h18
`define REG_IRQ_STATUS     8'h1C
`define REG_IRQ_MASK       8'h20
`define REG_RPDO_EXPECT    8'h24
`define REG_COB_PAGE       3'h2

`define CTRL_SINGLE_BIT    0
`define CTRL_SYNC_PROD_BIT 1
`define MOD_SYNC_TOUT_BIT  1
`define COB_FOLLOW_BIT     12
`define COB_SIZE_LSB       13
`define COB_EFF_LSB        16
`define IRQ_SYNC           0
`define IRQ_RPDO           1
`define IRQ_COB            2
`define IRQ_BUSOFF         3

`define COB_MIN            11'h181
`define COB_MAX            11'h5FF
`define TX_COB_BASE        11'h180
`define RX_COB_BASE        11'h200
`define COB_STEP           11'h100
`define COB_SIZE_DEF       2'h3
`define RPDO_EXPECT_DEF    10'h00F

`endif

// File: logic/node_status_ifs.sv
/*
  Interfaces between the status top and its pattern and timeout helpers.
  Assumes one clock; the user side drives the millisecond tick.
*/
`timescale 1ns/1ns

interface pattern_if;
  import node_status_pkg::*;
  led_mode_t mode;
  logic      ms_tick;
  logic      led;
  modport gen  (input mode, input ms_tick, output led);
  modport user (output mode, output ms_tick, input led);
endinterface

interface watch_if #(parameter int N = 1);
  logic          ms_tick;
  logic [15:0]   limit_ms;
  logic [N-1:0]  enable;
  logic [N-1:0]  seen;
  logic [N-1:0]  alive;
  logic [N-1:0]  timed_out;
  logic [N-1:0]  expired;
  modport mon  (input ms_tick, input limit_ms, input enable, input seen,
                output alive, output timed_out, output expired);
  modport user (output ms_tick, output limit_ms, output enable, output seen,
                input alive, input timed_out, input expired);
endinterface

// File: logic/node_status_pkg.sv
/*
  Types shared by the node status block.
  Assumes nothing beyond the defines header.
*/
package node_status_pkg;

  typedef enum logic [1:0] {NODE_STOPPED, NODE_PREOP, NODE_OPER} node_state_t;

  typedef enum logic [2:0] {BR_20K, BR_50K, BR_100K, BR_125K, BR_250K, BR_500K, BR_800K,
                            BR_1M} bitrate_t;

  typedef enum logic [2:0] {LED_OFF, LED_ON, LED_BLINK, LED_FLASH1, LED_FLASH3, LED_FLASH4,
                            LED_SLOW, LED_BUSOFF} led_mode_t;

endpackage

// File: logic/timeout_watch.sv
/*
  Per-channel reception supervision: alive while seen within the limit, timed out after.
  Assumes one-cycle seen pulses and a millisecond tick on the same clock.
*/
`timescale 1ns/1ns

module timeout_watch #(
  parameter int N = 1
)(
  input  wire logic clock,
  input  wire logic rst_n,
  watch_if.mon      w
);

  logic [15:0]  cnt_q [N];
  logic [N-1:0] alive_q;
  logic [N-1:0] tout_q;
  logic [N-1:0] exp_q;

  for (genvar i = 0; i < N; i++)
  begin : g_ch
    wire limit_hit = cnt_q[i] + 16'd1 >= w.limit_ms;

    always_ff @(posedge clock)
    begin
      exp_q[i] <= 1'b0;
      if (!rst_n || !w.enable[i])
      begin
        cnt_q[i]   <= 16'h0000;
        alive_q[i] <= 1'b0;
        tout_q[i]  <= 1'b0;
      end
      else if (w.seen[i])
      begin
        cnt_q[i]   <= 16'h0000;
        alive_q[i] <= 1'b1;
        tout_q[i]  <= 1'b0;
      end
      else if (alive_q[i] && w.ms_tick)
      begin
        if (limit_hit)
        begin
          alive_q[i] <= 1'b0;
          tout_q[i]  <= 1'b1;
          exp_q[i]   <= 1'b1;
        end
        else
          cnt_q[i] <= cnt_q[i] + 16'd1;
      end
    end
  end

  assign w.alive     = alive_q;
  assign w.timed_out = tout_q;
  assign w.expired   = exp_q;

endmodule
